/* File: include/regbank_pkg.sv */
// Package with register map, field positions, reset values and delay counts.
package regbank_pkg;
  localparam logic [7:0] ADDR_LINREG1_VOLT = 8'h02;
  localparam logic [7:0] ADDR_LINREG2_VOLT = 8'h03;
  localparam logic [7:0] ADDR_BUCK_PARAM   = 8'h04;
  localparam logic [7:0] ADDR_SYS_PARAM    = 8'h05;
  localparam logic [7:0] ADDR_BUCK_SLEW    = 8'h06;
  localparam logic [7:0] MASK_LINREG_VOLT  = 8'h3F;
  localparam logic [7:0] MASK_BUCK_PARAM   = 8'h7F;
  localparam logic [7:0] MASK_SYS_PARAM    = 8'h7F;
  localparam logic [7:0] MASK_BUCK_SLEW    = 8'h77;
  localparam logic [7:0] RST_LINREG_VOLT   = 8'h0C;
  localparam logic [7:0] RST_BUCK_PARAM    = 8'h0F;
  localparam logic [7:0] RST_SYS_PARAM     = 8'h2F;
  localparam logic [7:0] RST_BUCK_SLEW     = 8'h11;
  localparam logic [5:0] LINREG_CODE_MAX   = 6'h36;
  localparam int         LINREG_BASE_MV    = 900;
  localparam int         LINREG_STEP_MV    = 50;
  localparam int         POS_PHASE         = 6;
  localparam int         POS_ULTRA2        = 5;
  localparam int         POS_ULTRA1        = 4;
  localparam int         POS_DIS2          = 3;
  localparam int         POS_DIS1          = 2;
  localparam int         POS_MODE2         = 1;
  localparam int         POS_MODE1         = 0;
  localparam int         POS_SER_EN        = 6;
  localparam int         POS_POR_HI        = 5;
  localparam int         POS_POR_LO        = 4;
  localparam int         POS_EN_LINREG2    = 3;
  localparam int         POS_EN_LINREG1    = 2;
  localparam int         POS_EN_BUCK2      = 1;
  localparam int         POS_EN_BUCK1      = 0;
  localparam int         POS_SLEW2_HI      = 6;
  localparam int         POS_SLEW2_LO      = 4;
  localparam int         POS_SLEW1_HI      = 2;
  localparam int         POS_SLEW1_LO      = 0;
  localparam int         CLK_MHZ           = 25;
  localparam int         POR_DLY0_MS       = 1;
  localparam int         POR_DLY1_MS       = 50;
  localparam int         POR_DLY2_MS       = 150;
  localparam int         POR_DLY3_MS       = 200;
  localparam int         SLEW_BASE_NV_US   = 225;
endpackage : regbank_pkg

/* File: include/regfile_if.sv */
// Interface carrying register write strobes and stored values between modules.
`timescale 1ns/1ps
interface regfile_if;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] linreg1_r;
  logic [7:0] linreg2_r;
  logic [7:0] buck_param_r;
  logic [7:0] sys_param_r;
  logic [7:0] buck_slew_r;
  modport store (input wr_en, wr_addr, wr_data,
                 output linreg1_r, linreg2_r, buck_param_r, sys_param_r, buck_slew_r);
  modport user (output wr_en, wr_addr, wr_data,
                input linreg1_r, linreg2_r, buck_param_r, sys_param_r, buck_slew_r);
endinterface : regfile_if

/* File: rtl/reg_store.sv */
// Register storage for the five control registers with masking of reserved bits.
`timescale 1ns/1ps
module reg_store
  import regbank_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  regfile_if.store rf
);
  typedef struct packed {
    logic [7:0] lr1;
    logic [7:0] lr2;
    logic [7:0] bp;
    logic [7:0] sp;
    logic [7:0] sl;
  } store_t;
  store_t st_r;
  store_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (rf.wr_en) begin
      unique case (rf.wr_addr)
        ADDR_LINREG1_VOLT: st_nxt.lr1 = rf.wr_data & MASK_LINREG_VOLT;
        ADDR_LINREG2_VOLT: st_nxt.lr2 = rf.wr_data & MASK_LINREG_VOLT;
        ADDR_BUCK_PARAM:   st_nxt.bp  = rf.wr_data & MASK_BUCK_PARAM;
        ADDR_SYS_PARAM:    st_nxt.sp  = rf.wr_data & MASK_SYS_PARAM;
        ADDR_BUCK_SLEW:    st_nxt.sl  = rf.wr_data & MASK_BUCK_SLEW;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '{RST_LINREG_VOLT, RST_LINREG_VOLT, RST_BUCK_PARAM,
                RST_SYS_PARAM, RST_BUCK_SLEW};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rf.linreg1_r    = st_r.lr1;
  assign rf.linreg2_r    = st_r.lr2;
  assign rf.buck_param_r = st_r.bp;
  assign rf.sys_param_r  = st_r.sp;
  assign rf.buck_slew_r  = st_r.sl;

  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.lr1[7:6] == 2'b00) && (st_r.lr2[7:6] == 2'b00) && (st_r.bp[7] == 1'b0)
      && (st_r.sp[7] == 1'b0) && (st_r.sl[7] == 1'b0) && (st_r.sl[3] == 1'b0))
    else $error("Reserved bit set in storage.");
endmodule : reg_store

/* File: rtl/pmic_control_register_bank.sv */
// Control register bank of a dual buck and dual linear regulator controller.
// Contract
// - Linear regulator code six bits, reset 001100
// - Target is 0.90 V plus 50 mV per step
// - Parameter bit 6 selects buck phase relation
// - Bits 5,4 enable ultrasonic for buck 2,1
// - Bits 3,2 enable discharge, reset one
// - Bits 1,0 select auto or forced PWM
// - System bit 6 enables serial control
// - Power-on delay field selects 1/50/150/200 ms
// - System bits 3..0 enable the four regulators
// - Buck 2 slew field bits 6..4, reset 001
// - Buck 1 slew field bits 2..0, reset 001
// - All registers reset at start-up
// - Linear regulator registers at 0x02 and 0x03
`timescale 1ns/1ps
module pmic_control_register_bank
  import regbank_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wr_data,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic      [5:0]  linreg1_voltage_code,
  output logic      [5:0]  linreg2_voltage_code,
  output logic      [11:0] linreg1_target_mv,
  output logic      [11:0] linreg2_target_mv,
  output logic             linreg1_code_valid,
  output logic             linreg2_code_valid,
  output logic             buck_phase_select,
  output logic             buck2_ultrasonic_en,
  output logic             buck1_ultrasonic_en,
  output logic             buck2_discharge_en,
  output logic             buck1_discharge_en,
  output logic             buck2_auto_mode,
  output logic             buck1_auto_mode,
  output logic             serial_ctrl_en,
  output logic      [1:0]  buck_poweron_delay,
  output logic      [7:0]  buck_poweron_delay_ms,
  output logic             linreg2_en,
  output logic             linreg1_en,
  output logic             buck2_en,
  output logic             buck1_en,
  output logic      [2:0]  buck2_slew_code,
  output logic      [2:0]  buck1_slew_code,
  output logic      [15:0] buck2_slew_nv_us,
  output logic      [15:0] buck1_slew_nv_us
);
  regfile_if rf ();

  typedef struct packed {
    logic [7:0] rdat;
    logic       rvld;
  } rd_state_t;
  rd_state_t rs_r;
  rd_state_t rs_nxt;

  assign rf.wr_en   = wr_en;
  assign rf.wr_addr = addr;
  assign rf.wr_data = wr_data;

  reg_store u_store (
    .clk_sys (clk_sys),
    .rst     (rst),
    .rf      (rf)
  );

  // Reads of unmapped addresses return zero so software sees no stale data.
  always_comb begin
    rs_nxt      = rs_r;
    rs_nxt.rvld = rd_en;
    if (rd_en) begin
      unique case (addr)
        ADDR_LINREG1_VOLT: rs_nxt.rdat = rf.linreg1_r;
        ADDR_LINREG2_VOLT: rs_nxt.rdat = rf.linreg2_r;
        ADDR_BUCK_PARAM:   rs_nxt.rdat = rf.buck_param_r;
        ADDR_SYS_PARAM:    rs_nxt.rdat = rf.sys_param_r;
        ADDR_BUCK_SLEW:    rs_nxt.rdat = rf.buck_slew_r;
        default:           rs_nxt.rdat = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rs_r <= '0;
    end else begin
      rs_r <= rs_nxt;
    end
  end

  assign rd_data  = rs_r.rdat;
  assign rd_valid = rs_r.rvld;

  function automatic logic [11:0] linreg_mv(input logic [5:0] code);
    linreg_mv = 12'(LINREG_BASE_MV + LINREG_STEP_MV * int'(code));
  endfunction : linreg_mv

  function automatic logic [7:0] por_ms(input logic [1:0] sel);
    unique case (sel)
      2'b00: por_ms = 8'(POR_DLY0_MS);
      2'b01: por_ms = 8'(POR_DLY1_MS);
      2'b10: por_ms = 8'(POR_DLY2_MS);
      2'b11: por_ms = 8'(POR_DLY3_MS);
    endcase
  endfunction : por_ms

  // Slew rate in nV/us doubles per code step; 000 is the slowest ramp.
  function automatic logic [15:0] slew_nv(input logic [2:0] code);
    slew_nv = 16'(SLEW_BASE_NV_US << code);
  endfunction : slew_nv

  assign linreg1_voltage_code  = rf.linreg1_r[5:0];
  assign linreg2_voltage_code  = rf.linreg2_r[5:0];
  assign linreg1_target_mv     = linreg_mv(rf.linreg1_r[5:0]);
  assign linreg2_target_mv     = linreg_mv(rf.linreg2_r[5:0]);
  assign linreg1_code_valid    = rf.linreg1_r[5:0] <= LINREG_CODE_MAX;
  assign linreg2_code_valid    = rf.linreg2_r[5:0] <= LINREG_CODE_MAX;
  assign buck_phase_select     = rf.buck_param_r[POS_PHASE];
  assign buck2_ultrasonic_en   = rf.buck_param_r[POS_ULTRA2];
  assign buck1_ultrasonic_en   = rf.buck_param_r[POS_ULTRA1];
  // Discharge only acts while the buck is off, so it is gated by the enable.
  assign buck2_discharge_en    = rf.buck_param_r[POS_DIS2] & ~rf.sys_param_r[POS_EN_BUCK2];
  assign buck1_discharge_en    = rf.buck_param_r[POS_DIS1] & ~rf.sys_param_r[POS_EN_BUCK1];
  assign buck2_auto_mode       = rf.buck_param_r[POS_MODE2];
  assign buck1_auto_mode       = rf.buck_param_r[POS_MODE1];
  assign serial_ctrl_en        = rf.sys_param_r[POS_SER_EN];
  assign buck_poweron_delay    = rf.sys_param_r[POS_POR_HI:POS_POR_LO];
  assign buck_poweron_delay_ms = por_ms(rf.sys_param_r[POS_POR_HI:POS_POR_LO]);
  assign linreg2_en            = rf.sys_param_r[POS_EN_LINREG2];
  assign linreg1_en            = rf.sys_param_r[POS_EN_LINREG1];
  assign buck2_en              = rf.sys_param_r[POS_EN_BUCK2];
  assign buck1_en              = rf.sys_param_r[POS_EN_BUCK1];
  assign buck2_slew_code       = rf.buck_slew_r[POS_SLEW2_HI:POS_SLEW2_LO];
  assign buck1_slew_code       = rf.buck_slew_r[POS_SLEW1_HI:POS_SLEW1_LO];
  assign buck2_slew_nv_us      = slew_nv(buck2_slew_code);
  assign buck1_slew_nv_us      = slew_nv(buck1_slew_code);

  sequence s_wr(logic [7:0] a);
    wr_en && addr == a;
  endsequence

  chk_reset_values: assert property (@(posedge clk_sys)
    $fell(rst) |-> linreg1_voltage_code == 6'h0C && buck_poweron_delay == 2'b10
      && buck2_slew_code == 3'h1 && buck1_slew_code == 3'h1 && !serial_ctrl_en
      && {linreg2_en, linreg1_en, buck2_en, buck1_en} == 4'hF)
    else $error("Control outputs wrong after reset.");
  chk_linreg_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_wr(ADDR_LINREG2_VOLT) |=> linreg2_voltage_code == $past(wr_data[5:0]))
    else $error("Second linear regulator code not written.");
  chk_target_map: assert property (@(posedge clk_sys) disable iff (rst)
    linreg1_target_mv == 12'(900 + 50 * int'(linreg1_voltage_code)))
    else $error("Linear regulator target wrong.");
  chk_phase_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_wr(ADDR_BUCK_PARAM) |=> buck_phase_select == $past(wr_data[6])
      && buck1_ultrasonic_en == $past(wr_data[4]))
    else $error("Phase or ultrasonic bit not written.");
  chk_mode_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_wr(ADDR_BUCK_PARAM) |=> buck2_auto_mode == $past(wr_data[1]))
    else $error("Mode bit not written.");
  chk_discharge_off: assert property (@(posedge clk_sys) disable iff (rst)
    buck1_en |-> !buck1_discharge_en)
    else $error("Discharge active while buck enabled.");
  chk_enable_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_wr(ADDR_SYS_PARAM) |=> serial_ctrl_en == $past(wr_data[6])
      && linreg2_en == $past(wr_data[3]))
    else $error("System bits not written.");
  chk_delay_map: assert property (@(posedge clk_sys) disable iff (rst)
    buck_poweron_delay == 2'b11 |-> buck_poweron_delay_ms == 8'd200)
    else $error("Power-on delay mapping wrong.");
  chk_slew_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_wr(ADDR_BUCK_SLEW) |=> buck2_slew_code == $past(wr_data[6:4])
      && buck1_slew_code == $past(wr_data[2:0]))
    else $error("Slew fields not written.");
  chk_read_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    rd_en && addr == ADDR_LINREG1_VOLT |=> rd_valid && rd_data[7:6] == 2'b00)
    else $error("Reserved bits read nonzero.");
endmodule : pmic_control_register_bank

/* File: sim/host_model.sv */
// Host-side model issuing single-byte register writes and reads.
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_sys,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] addr,
  output logic      [7:0] wr_data,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial begin
    {wr_en, rd_en, addr, wr_data} = 18'h00000;
  end
  // Released lines show the inverse of the last value, so stale data is never trusted.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    {wr_en, addr, wr_data} = {1'b1, a, v};
    @(negedge clk_sys);
    {wr_en, addr, wr_data} = {1'b0, ~a, ~v};
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v, output logic ok);
    @(negedge clk_sys);
    {rd_en, addr} = {1'b1, a};
    @(negedge clk_sys);
    {rd_en, addr} = {1'b0, ~a};
    v = rd_data;
    ok = rd_valid;
  endtask : rd_reg
endmodule : host_model

/* File: sim/pmic_control_register_bank_tb.sv */
// Self-checking bench for the control register bank.
`timescale 1ns/1ps
module pmic_control_register_bank_tb;
  import regbank_pkg::*;
  logic        clk_sys, rst, wr_en, rd_en, rd_valid, serial_ctrl_en;
  logic        buck_phase_select, buck2_ultrasonic_en, buck1_ultrasonic_en;
  logic        buck2_discharge_en, buck1_discharge_en, buck2_auto_mode, buck1_auto_mode;
  logic        linreg2_en, linreg1_en, buck2_en, buck1_en;
  logic        linreg1_code_valid, linreg2_code_valid;
  logic [7:0]  addr, wr_data, rd_data, buck_poweron_delay_ms;
  logic [5:0]  linreg1_voltage_code, linreg2_voltage_code;
  logic [11:0] linreg1_target_mv, linreg2_target_mv;
  logic [1:0]  buck_poweron_delay;
  logic [2:0]  buck2_slew_code, buck1_slew_code;
  logic [15:0] buck2_slew_nv_us, buck1_slew_nv_us;
  int          bad_count = 0, n_compared = 0, cycles = 0;
  wire  [6:0]  bp = {buck_phase_select, buck2_ultrasonic_en, buck1_ultrasonic_en,
                     buck2_discharge_en, buck1_discharge_en, buck2_auto_mode, buck1_auto_mode};
  wire  [3:0]  ens = {linreg2_en, linreg1_en, buck2_en, buck1_en};
  pmic_control_register_bank pmic_control_register_bank_i (
    .clk_sys, .rst, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid,
    .linreg1_voltage_code, .linreg2_voltage_code, .linreg1_target_mv, .linreg2_target_mv,
    .linreg1_code_valid, .linreg2_code_valid, .buck_phase_select, .buck2_ultrasonic_en,
    .buck1_ultrasonic_en, .buck2_discharge_en, .buck1_discharge_en, .buck2_auto_mode,
    .buck1_auto_mode, .serial_ctrl_en, .buck_poweron_delay, .buck_poweron_delay_ms,
    .linreg2_en, .linreg1_en, .buck2_en, .buck1_en, .buck2_slew_code, .buck1_slew_code,
    .buck2_slew_nv_us, .buck1_slew_nv_us);
  host_model host_model_i (.clk_sys, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // The whole run needs well under 600 cycles; the ceiling leaves ample margin.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    logic       ok;
    host_model_i.rd_reg(a, v, ok);
    check(16'(ok), 16'h0001);
    check(16'(v), 16'(exp));
  endtask : rd_chk
  task automatic t_reset();
    rd_chk(8'h02, 8'h0C);
    rd_chk(8'h03, 8'h0C);
    rd_chk(8'h04, 8'h0F);
    rd_chk(8'h05, 8'h2F);
    rd_chk(8'h06, 8'h11);
    check(16'(linreg1_target_mv), 16'h05DC);
    check(16'(buck_poweron_delay_ms), 16'h0096);
    check(16'({buck2_discharge_en, buck1_discharge_en}), 16'h0000);
    check(buck1_slew_nv_us, 16'h01C2);
  endtask : t_reset
  task automatic t_reserved();
    logic [7:0] exp [6] = '{8'h3F, 8'h3F, 8'h7F, 8'h7F, 8'h77, 8'h00};
    for (int i = 0; i < 6; i++) begin
      host_model_i.wr_reg(8'(i + 2), 8'hFF);
      rd_chk(8'(i + 2), exp[i]);
    end
    rd_chk(8'h00, 8'h00);
    check(16'(buck_poweron_delay_ms), 16'h00C8);
    check(16'({serial_ctrl_en, buck2_discharge_en, buck1_discharge_en}), 16'h0004);
  endtask : t_reserved
  task automatic t_linreg();
    logic [5:0] c [6] = '{6'h00, 6'h01, 6'h35, 6'h36, 6'h37, 6'h3F};
    logic [5:0] n;
    for (int i = 0; i < 6; i++) begin
      n = ~c[i];
      host_model_i.wr_reg(8'h02, {2'b00, c[i]});
      host_model_i.wr_reg(8'h03, {2'b00, n});
      check(16'(linreg1_voltage_code), 16'(c[i]));
      check(16'(linreg2_voltage_code), 16'(n));
      check(16'(linreg1_target_mv), 16'(900 + 50 * c[i]));
      check(16'(linreg2_target_mv), 16'(900 + 50 * n));
      check(16'({linreg1_code_valid, linreg2_code_valid}), 16'({c[i] <= 6'h36, n <= 6'h36}));
    end
  endtask : t_linreg
  task automatic t_fields();
    logic [7:0] ms [4] = '{8'h01, 8'h32, 8'h96, 8'hC8};
    host_model_i.wr_reg(8'h05, 8'h00);
    check(16'({serial_ctrl_en, ens}), 16'h0000);
    for (int i = 0; i < 7; i++) begin
      host_model_i.wr_reg(8'h04, 8'(1 << i));
      check(16'(bp), 16'(1 << i));
    end
    for (int i = 0; i < 4; i++) begin
      host_model_i.wr_reg(8'h05, 8'((i << 4) | (1 << i)));
      check(16'(buck_poweron_delay), 16'(i));
      check(16'(buck_poweron_delay_ms), 16'(ms[i]));
      check(16'(ens), 16'(1 << i));
    end
    host_model_i.wr_reg(8'h04, 8'h0C);
    host_model_i.wr_reg(8'h05, 8'h0E);
    check(16'({buck2_discharge_en, buck1_discharge_en}), 16'h0001);
  endtask : t_fields
  task automatic t_slew();
    for (int i = 0; i < 8; i++) begin
      host_model_i.wr_reg(8'h06, 8'((i << 4) | (7 - i)));
      check(16'({buck2_slew_code, buck1_slew_code}), 16'((i << 3) | (7 - i)));
      check(buck2_slew_nv_us, 16'(225 << i));
      check(buck1_slew_nv_us, 16'(225 << (7 - i)));
    end
  endtask : t_slew
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  initial begin
    rst = 1'b1;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_reserved();
    t_linreg();
    t_fields();
    t_slew();
    // A second reset mid-run must bring back every default, not only the first one.
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    wrap_up();
  end
endmodule : pmic_control_register_bank_tb
